// file: rtl/psu_sync_update.sv
// The register offsets and strobed register access are this design's own decisions.
`default_nettype none
module psu_sync_update
  import psu_pkg::*;
#(
  parameter int NCH  = 4,   // Channels
  parameter int DW   = 16,  // Duty, period, dead-time width
  parameter int UPRW = 4,   // Update period field width
  parameter int NCMP = 8    // Comparison match inputs
) (
  input  wire logic            core_clk_in,       // Peripheral clock, 125 MHz
  input  wire logic            rstn_in,           // Async reset, active low
  input  wire logic [7:0]      addr_in,           // Register byte address
  input  wire logic [31:0]     wdata_in,          // Write data
  input  wire logic            wr_in,             // Write strobe
  input  wire logic            rd_in,             // Read strobe
  output logic      [31:0]     rdata_out,         // Read data, cycle after strobe
  input  wire logic            period_start_in,   // Sync PWM period start pulse
  input  wire logic [NCMP-1:0] cmp_match_in,      // Comparison match pulses
  output logic                 irq_out,           // Interrupt, level
  output logic                 dma_req_out,       // DMA transfer request, level
  output logic      [NCH-1:0]  sync_mask_out,     // Synchronous channel set
  output logic      [NCH-1:0]  chan_en_out,       // Channel enables
  output logic      [DW-1:0]   duty_out,          // Active duty value
  output logic      [DW-1:0]   period_out,        // Active period value
  output logic      [DW-1:0]   deadtime_out,      // Active dead-time value
  output logic                 duty_update_out    // Duty applied pulse
);

  typedef struct packed {
    logic [NCH-1:0]      sync_sel;
    logic [NCH-1:0]      chan_en;
    logic [METHOD_W-1:0] method;
    logic                timing;
    logic [CMPSEL_W-1:0] cmp_sel;
    logic                unlock;
    logic [DW-1:0]       duty_pend;
    logic [DW-1:0]       duty_act;
    logic [DW-1:0]       per_upd;
    logic [DW-1:0]       per_act;
    logic [DW-1:0]       dt_upd;
    logic [DW-1:0]       dt_act;
    logic                duty_seen;
    logic [STAT_W-1:0]   status;
    logic [STAT_W-1:0]   mask;
    logic                irq;
    logic                dma_req;
    logic                duty_strobe;
    logic [31:0]         rdata;
  } psu_ctrl_s;

  psu_ctrl_s         s_q;
  psu_ctrl_s         s_d;
  logic              auto_mode;
  logic              duty_wr;
  logic              trig;
  logic              stat_rd;
  logic [STAT_W-1:0] ev;

  psu_link_if #(.UPRW(UPRW)) ui ();

  ////////////////////////////////////////////////////////////////////////
  // Update period counter
  psu_period_cnt #(
    .UPRW (UPRW)
  ) u_cnt (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .ui          (ui)
  );

  assign ui.period_start = period_start_in;
  assign ui.run          = auto_mode && s_q.chan_en[CH0_ENABLE_BIT];
  assign ui.shadow_wr    = wr_in && (addr_in == OFF_UPDATE_PERIOD_SHADOW);
  assign ui.direct_wr    = wr_in && (addr_in == OFF_SYNC_UPDATE_PERIOD);
  assign ui.wdata        = wdata_in[UPR_LSB +: UPRW];

  ////////////////////////////////////////////////////////////////////////
  // Events
  assign auto_mode = (s_q.method == METHOD_AUTO_DMA);
  assign duty_wr   = wr_in && (addr_in == OFF_DUTY_UPDATE);
  assign stat_rd   = rd_in && (addr_in == OFF_SECOND_INT_STATUS);
  assign trig      = auto_mode && (s_q.timing ? cmp_match_in[s_q.cmp_sel] : ui.period_end);
  assign ev[STAT_WRITE_READY_FLAG_BIT] = trig;
  assign ev[STAT_DMA_UNDERRUN_FLAG_BIT] = auto_mode && ui.period_end && !s_q.duty_seen;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d             = s_q;
    s_d.duty_strobe = 1'b0;
    s_d.rdata       = '0;
    // Pending period and dead-time move at next period start
    if (s_q.unlock && period_start_in) begin
      s_d.per_act = s_q.per_upd;
      s_d.dt_act  = s_q.dt_upd;
      s_d.unlock  = 1'b0;
    end
    if (wr_in) begin
      case (addr_in)
        OFF_SYNC_CHANNEL_MODE: begin
          s_d.sync_sel = wdata_in[SCM_SYNC_LSB +: NCH];
          s_d.method   = wdata_in[SCM_METHOD_LSB +: METHOD_W];
          s_d.timing   = wdata_in[SCM_TIMING_BIT];
          s_d.cmp_sel  = wdata_in[SCM_CMPSEL_LSB +: CMPSEL_W];
        end
        OFF_SYNC_UPDATE_CONTROL: begin
          if (wdata_in[UNLOCK_BIT]) begin
            s_d.unlock = 1'b1;
          end
        end
        OFF_SECOND_INT_MASK: s_d.mask = wdata_in[STAT_W-1:0];
        OFF_DUTY_UPDATE: begin
          s_d.duty_pend = wdata_in[DW-1:0];
          s_d.dma_req   = 1'b0;
        end
        OFF_PERIOD_UPDATE:   s_d.per_upd = wdata_in[DW-1:0];
        OFF_DEADTIME_UPDATE: s_d.dt_upd  = wdata_in[DW-1:0];
        OFF_CHANNEL_ENABLE: begin
          // Channel zero brings all synchronous channels along
          s_d.chan_en = s_q.chan_en | wdata_in[NCH-1:0] |
                        (wdata_in[CH0_ENABLE_BIT] ? s_q.sync_sel : '0);
        end
        OFF_CHANNEL_DISABLE: begin
          s_d.chan_en = s_q.chan_en & ~(wdata_in[NCH-1:0] |
                        (wdata_in[CH0_ENABLE_BIT] ? s_q.sync_sel : '0));
        end
        default: ;
      endcase
    end
    // Duty applied automatically at each update period end
    if (auto_mode && ui.period_end) begin
      s_d.duty_act    = s_q.duty_pend;
      s_d.duty_strobe = 1'b1;
      s_d.duty_seen   = duty_wr;
    end else if (duty_wr) begin
      s_d.duty_seen = 1'b1;
    end
    if (trig) begin
      s_d.dma_req = 1'b1;
    end
    if (stat_rd) begin
      s_d.status = '0;
    end
    s_d.status = s_d.status | ev;
    s_d.irq    = |(s_d.status & s_d.mask);
    if (rd_in) begin
      case (addr_in)
        OFF_SYNC_CHANNEL_MODE: begin
          s_d.rdata[SCM_SYNC_LSB +: NCH]        = s_q.sync_sel;
          s_d.rdata[SCM_METHOD_LSB +: METHOD_W] = s_q.method;
          s_d.rdata[SCM_TIMING_BIT]             = s_q.timing;
          s_d.rdata[SCM_CMPSEL_LSB +: CMPSEL_W] = s_q.cmp_sel;
        end
        OFF_SYNC_UPDATE_CONTROL: s_d.rdata[UNLOCK_BIT] = s_q.unlock;
        OFF_SYNC_UPDATE_PERIOD: begin
          s_d.rdata[UPR_LSB +: UPRW]    = ui.update_period_value;
          s_d.rdata[UPRCNT_LSB +: UPRW] = ui.cnt;
        end
        OFF_SECOND_INT_MASK:   s_d.rdata[STAT_W-1:0] = s_q.mask;
        OFF_SECOND_INT_STATUS: s_d.rdata[STAT_W-1:0] = s_q.status;
        OFF_PERIOD_UPDATE:     s_d.rdata[DW-1:0]     = s_q.per_upd;
        OFF_DEADTIME_UPDATE:   s_d.rdata[DW-1:0]     = s_q.dt_upd;
        OFF_CHANNEL_ENABLE:    s_d.rdata[NCH-1:0]    = s_q.chan_en;
        OFF_ACTIVE_DUTY:       s_d.rdata[DW-1:0]     = s_q.duty_act;
        OFF_ACTIVE_PERIOD:     s_d.rdata[DW-1:0]     = s_q.per_act;
        OFF_ACTIVE_DEADTIME:   s_d.rdata[DW-1:0]     = s_q.dt_act;
        default:               s_d.rdata             = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata_out       = s_q.rdata;
  assign irq_out         = s_q.irq;
  assign dma_req_out     = s_q.dma_req;
  assign sync_mask_out   = s_q.sync_sel;
  assign chan_en_out     = s_q.chan_en;
  assign duty_out        = s_q.duty_act;
  assign period_out      = s_q.per_act;
  assign deadtime_out    = s_q.dt_act;
  assign duty_update_out = s_q.duty_strobe;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_unlock_start;
    s_q.unlock && period_start_in;
  endsequence

  sequence s_end_without_duty;
    auto_mode && ui.period_end && !s_q.duty_seen;
  endsequence

  a_underrun_set: assert property (s_end_without_duty |=> s_q.status[STAT_DMA_UNDERRUN_FLAG_BIT] ##1 (irq_out || !s_q.mask[STAT_DMA_UNDERRUN_FLAG_BIT] || stat_rd || $past(stat_rd)))
    else $error("underrun flag not raised");
  a_status_rd_clear: assert property (stat_rd && ev == '0 |=> s_q.status == '0 && !irq_out)
    else $error("status read did not clear flags");
  a_irq_masked: assert property (irq_out == |(s_q.status & s_q.mask))
    else $error("interrupt does not follow masked status");
  a_duty_auto: assert property (auto_mode && ui.period_end |=> duty_out == $past(s_q.duty_pend) && duty_update_out)
    else $error("duty not applied at update period end");
  a_sync_enable: assert property (wr_in && addr_in == OFF_CHANNEL_ENABLE && wdata_in[CH0_ENABLE_BIT]
                                  |=> (chan_en_out & sync_mask_out) == sync_mask_out)
    else $error("synchronous channels not enabled together");
  a_req_end_period: assert property (auto_mode && !s_q.timing && ui.period_end
                                     |=> dma_req_out && s_q.status[STAT_WRITE_READY_FLAG_BIT])
    else $error("request missing at update period end");
  a_req_on_compare: assert property (auto_mode && s_q.timing && cmp_match_in[s_q.cmp_sel]
                                     |=> dma_req_out && s_q.status[STAT_WRITE_READY_FLAG_BIT])
    else $error("request missing on compare match");
  a_unlock_xfer: assert property (s_unlock_start |=> period_out == $past(s_q.per_upd)
                                  && deadtime_out == $past(s_q.dt_upd))
    else $error("pending period or dead-time not transferred");
  a_unlock_clear: assert property (s_unlock_start and !(wr_in && addr_in == OFF_SYNC_UPDATE_CONTROL)
                                   |=> !s_q.unlock)
    else $error("unlock bit not cleared at transfer");
  a_unlock_hold: assert property (s_q.unlock && !period_start_in |=> s_q.unlock && period_out == $past(period_out))
    else $error("transfer happened before period start");

endmodule
`default_nettype wire

// file: rtl/psu_pkg.sv
`default_nettype none
package psu_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_SYNC_CHANNEL_MODE   = 8'h00;
  localparam logic [7:0] OFF_SYNC_UPDATE_CONTROL = 8'h04;
  localparam logic [7:0] OFF_SYNC_UPDATE_PERIOD  = 8'h08;
  localparam logic [7:0] OFF_UPDATE_PERIOD_SHADOW = 8'h0C;
  localparam logic [7:0] OFF_SECOND_INT_MASK     = 8'h10;
  localparam logic [7:0] OFF_SECOND_INT_STATUS   = 8'h14;
  localparam logic [7:0] OFF_DUTY_UPDATE         = 8'h18;
  localparam logic [7:0] OFF_PERIOD_UPDATE       = 8'h1C;
  localparam logic [7:0] OFF_DEADTIME_UPDATE     = 8'h20;
  localparam logic [7:0] OFF_CHANNEL_ENABLE      = 8'h24;
  localparam logic [7:0] OFF_CHANNEL_DISABLE     = 8'h28;
  localparam logic [7:0] OFF_ACTIVE_DUTY         = 8'h2C;
  localparam logic [7:0] OFF_ACTIVE_PERIOD       = 8'h30;
  localparam logic [7:0] OFF_ACTIVE_DEADTIME     = 8'h34;
  // Sync channel mode register fields
  localparam int SCM_SYNC_LSB   = 0;
  localparam int SCM_METHOD_LSB = 16;
  localparam int METHOD_W       = 2;
  localparam int SCM_TIMING_BIT = 20;
  localparam int SCM_CMPSEL_LSB = 21;
  localparam int CMPSEL_W       = 3;
  localparam logic [1:0] METHOD_AUTO_DMA = 2'h2;
  // Other bit and field positions
  localparam int UNLOCK_BIT     = 0;
  localparam int CH0_ENABLE_BIT = 0;
  localparam int UPR_LSB        = 0;
  localparam int UPRCNT_LSB     = 8;
  // Second status / mask layout
  localparam int STAT_W        = 2;
  localparam int STAT_WRITE_READY_FLAG_BIT = 0;
  localparam int STAT_DMA_UNDERRUN_FLAG_BIT = 1;
  // Reset values
  localparam logic [STAT_W-1:0] RST_MASK   = 2'h0;
  localparam logic [1:0]        RST_METHOD = 2'h0;
endpackage
`default_nettype wire

// file: rtl/psu_link_if.sv
`default_nettype none
interface psu_link_if #(
  parameter int UPRW = 4
) ();
  logic            period_start;
  logic            run;
  logic            shadow_wr;
  logic            direct_wr;
  logic [UPRW-1:0] wdata;
  logic [UPRW-1:0] update_period_value;
  logic [UPRW-1:0] cnt;
  logic            period_end;
  logic            pend;

  modport ctrl (output period_start, run, shadow_wr, direct_wr, wdata,
                input  update_period_value, cnt, period_end, pend);
  modport cnt_side (input  period_start, run, shadow_wr, direct_wr, wdata,
                    output update_period_value, cnt, period_end, pend);
endinterface
`default_nettype wire

// file: rtl/psu_period_cnt.sv
`default_nettype none
module psu_period_cnt
  import psu_pkg::*;
#(
  parameter int UPRW = 4
) (
  input  wire logic       core_clk_in,  // Peripheral clock
  input  wire logic       rstn_in,      // Async reset, active low
  psu_link_if.cnt_side    ui            // Link to control block
);

  typedef struct packed {
    logic [UPRW-1:0] update_period_value;
    logic [UPRW-1:0] cnt;
    logic [UPRW-1:0] shadow;
    logic            pend;
  } psu_cnt_s;

  psu_cnt_s s_q;
  psu_cnt_s s_d;
  logic     wrap;

  ////////////////////////////////////////////////////////////////////////
  assign wrap          = ui.period_start && ui.run && (s_q.cnt == s_q.update_period_value);
  assign ui.period_end = wrap;
  assign ui.update_period_value        = s_q.update_period_value;
  assign ui.cnt        = s_q.cnt;
  assign ui.pend       = s_q.pend;

  always_comb begin
    s_d = s_q;
    if (ui.direct_wr) begin
      s_d.update_period_value = ui.wdata;
    end
    if (ui.period_start && ui.run) begin
      if (wrap) begin
        s_d.cnt = '0;
        if (s_q.pend) begin
          s_d.update_period_value  = s_q.shadow;
          s_d.pend = 1'b0;
        end
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
    if (ui.shadow_wr) begin
      s_d.shadow = ui.wdata;
      s_d.pend   = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_wrap_pending;
    s_q.pend && !ui.direct_wr ##0 wrap;
  endsequence

  a_cnt_wraps_zero: assert property (wrap |=> s_q.cnt == '0)
    else $error("update period counter did not wrap");
  a_cnt_steps_up: assert property (ui.period_start && ui.run && !wrap |=> s_q.cnt == $past(s_q.cnt) + 1'b1)
    else $error("update period counter did not advance");
  a_shadow_loads: assert property (s_wrap_pending |=> s_q.update_period_value == $past(s_q.shadow))
    else $error("shadow period not loaded at wrap");
  a_shadow_waits: assert property (s_q.pend && !wrap && !ui.direct_wr |=> s_q.update_period_value == $past(s_q.update_period_value))
    else $error("update period changed before wrap");

endmodule
`default_nettype wire

// file: testbench/psu_dma_model.sv
`default_nettype none
module psu_dma_model
  import psu_pkg::*;
(
  input  wire logic        core_clk_in,   // Peripheral clock
  input  wire logic        rstn_in,       // Async reset, active low
  input  wire logic        req_in,        // DMA transfer request
  input  wire logic        en_in,         // Channel armed
  input  wire logic [3:0]  delay_in,      // Answer delay, cycles
  output logic             wr_out,        // Write strobe
  output logic      [7:0]  addr_out,      // Write address
  output logic      [31:0] wdata_out,     // Write data
  output logic      [15:0] last_out,      // Last duty value sent
  output logic      [7:0]  count_out      // Duty words sent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic [1:0] gap_q;

  ////////////////////////////////////////////////////////////
  // One duty word per request, after a settable delay
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_out <= 1'b0;
      addr_out <= 8'h00;
      wdata_out <= 32'h0;
      last_out <= 16'h0;
      count_out <= 8'h00;
      wait_q <= 4'h0;
      gap_q <= 2'h0;
    end else begin
      wr_out <= 1'b0;
      if (gap_q != 2'h0) begin
        gap_q <= gap_q - 2'h1;
      end else if (en_in && req_in) begin
        if (wait_q == delay_in) begin
          wr_out <= 1'b1;
          addr_out <= OFF_DUTY_UPDATE;
          wdata_out <= {16'h0, last_out + 16'h0020};
          last_out <= last_out + 16'h0020;
          count_out <= count_out + 8'h01;
          wait_q <= 4'h0;
          gap_q <= 2'h3;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/psu_sync_update_bench.sv
`default_nettype none
module psu_sync_update_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import psu_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        tb_wr = 1'b0;
  logic        tb_rd = 1'b0;
  logic [7:0]  tb_addr = 8'h00;
  logic [31:0] tb_wdata = 32'h0;
  logic        ps = 1'b0;
  logic [7:0]  cmp = 8'h00;
  logic        dma_en = 1'b0;
  logic        d_wr;
  logic [7:0]  d_addr;
  logic [31:0] d_wdata;
  logic [15:0] d_last;
  logic [7:0]  d_cnt;
  logic [31:0] rdata;
  logic        irq;
  logic        req;
  logic [3:0]  smask;
  logic [3:0]  chen;
  logic [15:0] duty;
  logic [15:0] per;
  logic [15:0] dt;
  logic        upd;
  int          fails = 0;
  int          check_count = 0;
  int          upd_n = 0;
  int          cyc = 0;
  int          n;
  logic [7:0]  ra [4] = '{8'h00, 8'h08, 8'h10, 8'h3C};
  logic [31:0] rw [4] = '{32'h00A20005, 32'h1, 32'h3, 32'hFFFFFFFF};
  logic [31:0] re [4] = '{32'h00A20005, 32'h1, 32'h3, 32'h0};

  always #4 clk = ~clk;

  psu_sync_update dut (.core_clk_in(clk), .rstn_in(rstn), .addr_in(d_wr ? d_addr : tb_addr),
    .wdata_in(d_wr ? d_wdata : tb_wdata), .wr_in(tb_wr | d_wr), .rd_in(tb_rd), .rdata_out(rdata),
    .period_start_in(ps), .cmp_match_in(cmp), .irq_out(irq), .dma_req_out(req),
    .sync_mask_out(smask), .chan_en_out(chen), .duty_out(duty), .period_out(per),
    .deadtime_out(dt), .duty_update_out(upd));

  psu_dma_model dma (.core_clk_in(clk), .rstn_in(rstn), .req_in(req), .en_in(dma_en), .delay_in(4'h1),
    .wr_out(d_wr), .addr_out(d_addr), .wdata_out(d_wdata), .last_out(d_last), .count_out(d_cnt));

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    tb_wr <= 1'b1;
    tb_addr <= a;
    tb_wdata <= d;
    @(posedge clk);
    tb_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input bit cmpr);
    @(posedge clk);
    tb_rd <= 1'b1;
    tb_addr <= a;
    @(posedge clk);
    tb_rd <= 1'b0;
    @(negedge clk);
    if (cmpr) check(rdata, exp);
  endtask

  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clk);
      ps <= 1'b1;
      @(posedge clk);
      ps <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////
  // Applied duty is the word sent before the update
  always @(posedge clk) begin
    cyc++;
    if (upd === 1'b1) begin
      upd_n++;
      check({16'h0, duty}, {16'h0, d_last});
    end
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check({irq, req, chen, duty}, 22'h0);
    rd_reg(OFF_SECOND_INT_MASK, {30'h0, RST_MASK}, 1);
    for (int i = 0; i < 4; i++) begin
      wr_reg(ra[i], rw[i]);
      rd_reg(ra[i], re[i], 1);
    end
    check(smask, 4'h5);
    wr_reg(OFF_SYNC_CHANNEL_MODE, 32'h0002000F);
    dma_en <= 1'b1;
    wr_reg(OFF_CHANNEL_ENABLE, 32'h1);
    @(negedge clk);
    check({smask, chen}, 8'hFF);
    // Four update periods of two
    pulse(8);
    check(upd_n, 4);
    check(irq, 1'b1);
    rd_reg(OFF_SECOND_INT_STATUS, 32'h3, 1);
    pulse(4);
    rd_reg(OFF_SECOND_INT_STATUS, 32'h1, 1);
    rd_reg(OFF_SECOND_INT_STATUS, 32'h0, 1);
    // Stalled DMA: first period was fed, second is not
    dma_en <= 1'b0;
    pulse(4);
    check({req, irq}, 2'h3);
    rd_reg(OFF_SECOND_INT_STATUS, 32'h3, 1);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wr_reg(OFF_SECOND_INT_MASK, 32'h0);
    pulse(2);
    check(irq, 1'b0);
    rd_reg(OFF_SECOND_INT_STATUS, 32'h3, 1);
    wr_reg(OFF_SECOND_INT_MASK, 32'h3);
    dma_en <= 1'b1;
    repeat (10) @(posedge clk);
    check(req, 1'b0);
    // Request on compare match 5
    wr_reg(OFF_SYNC_CHANNEL_MODE, 32'h00B2000F);
    rd_reg(OFF_SECOND_INT_STATUS, 32'h0, 0);
    n = d_cnt;
    @(posedge clk);
    cmp <= 8'h10;
    @(posedge clk);
    cmp <= 8'h00;
    repeat (8) @(posedge clk);
    check(d_cnt, n);
    cmp <= 8'h20;
    @(posedge clk);
    cmp <= 8'h00;
    repeat (8) @(posedge clk);
    check(d_cnt, n + 1);
    rd_reg(OFF_SECOND_INT_STATUS, 32'h1, 1);
    wr_reg(OFF_SYNC_CHANNEL_MODE, 32'h0002000F);
    // Unlocked period and dead-time
    wr_reg(OFF_PERIOD_UPDATE, 32'h0123);
    wr_reg(OFF_DEADTIME_UPDATE, 32'h0045);
    wr_reg(OFF_SYNC_UPDATE_CONTROL, 32'h1);
    rd_reg(OFF_SYNC_UPDATE_CONTROL, 32'h1, 1);
    check(per, 16'h0);
    pulse(1);
    check({per, dt}, 32'h01230045);
    rd_reg(OFF_SYNC_UPDATE_CONTROL, 32'h0, 1);
    // Shadow update period
    n = upd_n;
    for (int i = 0; i < 3 && upd_n == n; i++) pulse(1);
    rd_reg(OFF_SECOND_INT_STATUS, 32'h0, 0);
    pulse(2);
    rd_reg(OFF_SECOND_INT_STATUS, 32'h1, 1);
    wr_reg(OFF_UPDATE_PERIOD_SHADOW, 32'h3);
    rd_reg(OFF_SYNC_UPDATE_PERIOD, 32'h001, 1);
    pulse(2);
    rd_reg(OFF_SYNC_UPDATE_PERIOD, 32'h003, 1);
    pulse(1);
    rd_reg(OFF_SYNC_UPDATE_PERIOD, 32'h103, 1);
    n = upd_n;
    pulse(3);
    check(upd_n, n + 1);
    // Other method freezes updates
    wr_reg(OFF_SYNC_CHANNEL_MODE, 32'h0000000F);
    n = upd_n;
    pulse(6);
    check(upd_n, n);
    rd_reg(OFF_ACTIVE_PERIOD, 32'h0123, 1);
    rd_reg(OFF_ACTIVE_DEADTIME, 32'h0045, 1);
    wr_reg(OFF_CHANNEL_DISABLE, 32'h1);
    @(negedge clk);
    check(chen, 4'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
